// ==== hdl/xma_top.sv ====
// Data memory decoder with on-chip expanded RAM and multiplexed external bus
//
// Function
// - 1024 bytes of on-chip expanded RAM sit in external data space from 00h to 3FFh.
// - Internal RAM 00h to 7Fh is reached by direct and by indirect addressing.
// - Internal RAM 80h to FFh is reached only indirectly, never hitting the registers there.
// - Special function space 80h to FFh is reached only directly and is separate storage.
// - With the disable bit at 0 both move forms below the visible size go to on-chip expanded RAM, not the bus.
// - An expanded RAM hit leaves the address/data port, high port and strobes unchanged.
// - Data-pointer moves above the visible expanded RAM size run a normal bus cycle.
// - Expanded RAM above 0FFh is reachable only by the data-pointer form of the move.
// - With the disable bit at 1 the index form puts an 8-bit address on the low port only.
// - The data-pointer form drives the high byte on the high port and muxes the low byte.
// - Every external bus move asserts the matching read or write strobe.
// - Two size-select bits shrink the visible expanded RAM, freeing space for peripherals.
// - The expanded RAM occupies the lowest addresses of external data space.
// - Stack accesses reach only the 256-byte internal RAM, never expanded RAM.
// - With the stretch bit set, bus strobe pulses and expanded RAM access pulses last 30 clocks instead of 6.
`timescale 1ns/1ps
`default_nettype none

module xma_top (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Core access port
  input wire logic core_req,
  input wire logic core_wr,
  input wire xma_pkg::xma_space_t core_space,
  input wire logic [15:0] core_addr,
  input wire logic [7:0] core_wdata,
  output logic core_busy_q,
  output logic core_ack_q,
  output logic [7:0] core_rdata_q,
  // External multiplexed bus
  input wire logic [7:0] low_addr_data_port_in,
  output logic [7:0] low_addr_data_port_out_q,
  output logic low_addr_data_port_oe_n_q,
  output logic [7:0] high_addr_port_q,
  output logic addr_latch_en_q,
  output logic rd_strobe_n_q,
  output logic wr_strobe_n_q,
  // Avalon-MM register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ==========================================================================
  // Decode helpers

  // Visible expanded RAM size for a size-select code
  function automatic logic [15:0] visible_size(input logic [1:0] sel);
    logic [15:0] size;
    size = xma_pkg::XSIZE_SEL3;
    if (sel == 2'h0) begin
      size = xma_pkg::XSIZE_SEL0;
    end else if (sel == 2'h1) begin
      size = xma_pkg::XSIZE_SEL1;
    end else if (sel == 2'h2) begin
      size = xma_pkg::XSIZE_SEL2;
    end
    return size;
  endfunction : visible_size

  // ==========================================================================
  // Storage and state
  logic [7:0] iram_q [0:xma_pkg::IRAM_BYTES-1];
  logic [7:0] sfr_q [0:xma_pkg::SFR_BYTES-1];
  logic [7:0] expanded_ram_q [0:xma_pkg::EXPANDED_RAM_BYTES-1];
  logic internal_xmem_disable_q;
  logic xmem_size_sel_lo_q;
  logic xmem_size_sel_hi_q;
  logic strobe_stretch_q;
  xma_pkg::xma_state_t state_q;
  logic [4:0] cnt_q;
  logic [4:0] pulse_len_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic wr_q;
  logic idx_form_q;
  logic last_ext_q;
  logic last_expanded_ram_q;
  logic [7:0] ad_meta_q;
  logic [7:0] ad_sync_q;
  logic avs_wait_q;
  logic [31:0] avs_rdata_q;

  // ==========================================================================
  // Request decode
  logic take;
  logic is_external_data_move;
  logic is_idx;
  logic [15:0] eff_addr;
  logic xhit;
  logic [7:0] int_rdata;
  logic pulse_last;

  assign take = core_req & ~core_busy_q;
  assign is_idx = (core_space == xma_pkg::XMA_EXTERNAL_DATA_MOVE_IDX);
  assign is_external_data_move = is_idx | (core_space == xma_pkg::XMA_EXTERNAL_DATA_MOVE_DATA_POINTER);
  // Index form only reaches the first 256 bytes
  assign eff_addr = is_idx ? {8'h00, core_addr[7:0]} : core_addr;
  // Expanded RAM hit from the lowest address up to the visible size
  assign xhit = is_external_data_move & ~internal_xmem_disable_q &
                (eff_addr < visible_size({xmem_size_sel_hi_q, xmem_size_sel_lo_q}));
  assign pulse_last = (cnt_q == pulse_len_q - 5'h01);

  // Internal read mux: direct high half goes to special function space
  always_comb begin
    int_rdata = iram_q[core_addr[7:0]];
    if (core_space == xma_pkg::XMA_DIRECT && core_addr[7:0] >= xma_pkg::UPPER_FIRST) begin
      int_rdata = sfr_q[core_addr[6:0]];
    end
  end

  // ==========================================================================
  // Pin synchroniser for the address/data port input
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ad_meta_q <= 8'h00;
      ad_sync_q <= 8'h00;
    end else if (clk_en) begin
      ad_meta_q <= low_addr_data_port_in;
      ad_sync_q <= ad_meta_q;
    end
  end

  // ==========================================================================
  // Access sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= xma_pkg::XMA_IDLE;
      cnt_q <= 5'h00;
      pulse_len_q <= xma_pkg::PULSE_STD_CLK;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      idx_form_q <= 1'b0;
      core_busy_q <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        xma_pkg::XMA_IDLE: begin
          cnt_q <= 5'h00;
          if (take && is_external_data_move) begin
            addr_q <= eff_addr;
            wdata_q <= core_wdata;
            wr_q <= core_wr;
            idx_form_q <= is_idx;
            core_busy_q <= 1'b1;
            // Stretched strobe length for slow parts
            pulse_len_q <= strobe_stretch_q ? xma_pkg::PULSE_STR_CLK : xma_pkg::PULSE_STD_CLK;
            state_q <= xhit ? xma_pkg::XMA_XWAIT : xma_pkg::XMA_ALE;
          end
        end
        xma_pkg::XMA_XWAIT: begin
          cnt_q <= cnt_q + 5'h01;
          if (pulse_last) begin
            state_q <= xma_pkg::XMA_IDLE;
            core_busy_q <= 1'b0;
          end
        end
        xma_pkg::XMA_ALE: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == xma_pkg::ALE_CLK - 5'h01) begin
            cnt_q <= 5'h00;
            state_q <= xma_pkg::XMA_STROBE;
          end
        end
        xma_pkg::XMA_STROBE: begin
          cnt_q <= cnt_q + 5'h01;
          if (pulse_last) begin
            cnt_q <= 5'h00;
            state_q <= xma_pkg::XMA_HOLD;
          end
        end
        xma_pkg::XMA_HOLD: begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == xma_pkg::HOLD_CLK - 5'h01) begin
            state_q <= xma_pkg::XMA_IDLE;
            core_busy_q <= 1'b0;
          end
        end
        default: begin
          state_q <= xma_pkg::XMA_IDLE;
          core_busy_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Internal RAM and special function space writes, stack only to internal RAM
  always_ff @(posedge sys_clk) begin
    if (clk_en && !srst && take && core_wr && !is_external_data_move) begin
      if (core_space == xma_pkg::XMA_DIRECT && core_addr[7:0] >= xma_pkg::UPPER_FIRST) begin
        sfr_q[core_addr[6:0]] <= core_wdata;
      end else begin
        iram_q[core_addr[7:0]] <= core_wdata;
      end
    end
  end

  // Expanded RAM write at the end of the access pulse
  always_ff @(posedge sys_clk) begin
    if (clk_en && !srst && state_q == xma_pkg::XMA_XWAIT && pulse_last && wr_q) begin
      expanded_ram_q[addr_q[9:0]] <= wdata_q;
    end
  end

  // ==========================================================================
  // Core answer: internal next cycle, moves at end of their cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      core_ack_q <= 1'b0;
      core_rdata_q <= 8'h00;
      last_ext_q <= 1'b0;
      last_expanded_ram_q <= 1'b0;
    end else if (clk_en) begin
      core_ack_q <= 1'b0;
      if (state_q == xma_pkg::XMA_IDLE && take && !is_external_data_move) begin
        core_ack_q <= 1'b1;
        if (!core_wr) begin
          core_rdata_q <= int_rdata;
        end
      end else if (state_q == xma_pkg::XMA_XWAIT && pulse_last) begin
        core_ack_q <= 1'b1;
        last_expanded_ram_q <= 1'b1;
        last_ext_q <= 1'b0;
        if (!wr_q) begin
          core_rdata_q <= expanded_ram_q[addr_q[9:0]];
        end
      end else if (state_q == xma_pkg::XMA_STROBE && pulse_last && !wr_q) begin
        core_rdata_q <= ad_sync_q; // Sample bus data before the read strobe rises
      end else if (state_q == xma_pkg::XMA_HOLD && cnt_q == xma_pkg::HOLD_CLK - 5'h01) begin
        core_ack_q <= 1'b1;
        last_ext_q <= 1'b1;
        last_expanded_ram_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // External bus pins; outside ALE, STROBE and HOLD only ALE and the strobes are driven, to idle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      low_addr_data_port_out_q <= 8'h00;
      low_addr_data_port_oe_n_q <= 1'b1;
      high_addr_port_q <= 8'h00;
      addr_latch_en_q <= 1'b0;
      rd_strobe_n_q <= 1'b1;
      wr_strobe_n_q <= 1'b1;
    end else if (clk_en) begin
      case (state_q)
        xma_pkg::XMA_ALE: begin
          addr_latch_en_q <= 1'b1;
          low_addr_data_port_out_q <= addr_q[7:0];
          low_addr_data_port_oe_n_q <= 1'b0;
          if (!idx_form_q) begin
            high_addr_port_q <= addr_q[15:8];
          end
        end
        xma_pkg::XMA_STROBE: begin
          addr_latch_en_q <= 1'b0;
          rd_strobe_n_q <= wr_q;
          wr_strobe_n_q <= ~wr_q;
          low_addr_data_port_oe_n_q <= ~wr_q;
          if (wr_q) begin
            low_addr_data_port_out_q <= wdata_q;
          end
        end
        xma_pkg::XMA_HOLD: begin
          rd_strobe_n_q <= 1'b1;
          wr_strobe_n_q <= 1'b1;
          low_addr_data_port_oe_n_q <= 1'b1;
        end
        default: begin
          addr_latch_en_q <= 1'b0;
          rd_strobe_n_q <= 1'b1;
          wr_strobe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // Avalon-MM slave: one wait cycle, then waitrequest low for one cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      avs_wait_q <= 1'b1;
      avs_rdata_q <= 32'h00000000;
    end else if (clk_en) begin
      avs_wait_q <= 1'b1;
      if ((avs_read || avs_write) && avs_wait_q) begin
        avs_wait_q <= 1'b0;
        avs_rdata_q <= 32'h00000000;
        if (avs_read && avs_address == xma_pkg::REG_CTRL) begin
          avs_rdata_q[xma_pkg::CTRL_DIS_BIT] <= internal_xmem_disable_q;
          avs_rdata_q[xma_pkg::CTRL_SIZE_LO_BIT] <= xmem_size_sel_lo_q;
          avs_rdata_q[xma_pkg::CTRL_SIZE_HI_BIT] <= xmem_size_sel_hi_q;
          avs_rdata_q[xma_pkg::CTRL_STRETCH_BIT] <= strobe_stretch_q;
        end else if (avs_read && avs_address == xma_pkg::REG_STAT) begin
          avs_rdata_q[xma_pkg::STAT_BUSY_BIT] <= core_busy_q;
          avs_rdata_q[xma_pkg::STAT_EXT_BIT] <= last_ext_q;
          avs_rdata_q[xma_pkg::STAT_EXPANDED_RAM_BIT] <= last_expanded_ram_q;
          avs_rdata_q[xma_pkg::STAT_WR_BIT] <= wr_q;
        end
      end
    end
  end

  // Control register write at the edge where waitrequest is seen low
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      internal_xmem_disable_q <= xma_pkg::CTRL_DIS_RST;
      xmem_size_sel_lo_q <= xma_pkg::CTRL_SIZE_RST[0];
      xmem_size_sel_hi_q <= xma_pkg::CTRL_SIZE_RST[1];
      strobe_stretch_q <= xma_pkg::CTRL_STRETCH_RST;
    end else if (clk_en && avs_write && !avs_wait_q && avs_byteenable[0] &&
                 avs_address == xma_pkg::REG_CTRL) begin
      internal_xmem_disable_q <= avs_writedata[xma_pkg::CTRL_DIS_BIT];
      xmem_size_sel_lo_q <= avs_writedata[xma_pkg::CTRL_SIZE_LO_BIT];
      xmem_size_sel_hi_q <= avs_writedata[xma_pkg::CTRL_SIZE_HI_BIT];
      strobe_stretch_q <= avs_writedata[xma_pkg::CTRL_STRETCH_BIT];
    end
  end

  assign avs_waitrequest = avs_wait_q;
  assign avs_readdata = avs_rdata_q;

endmodule : xma_top

`default_nettype wire

// ==== include/xma_pkg.sv ====
// Constants and types shared by the expanded data memory access block
package xma_pkg;

  // ==========================================================================
  // Memory sizes and address limits
  localparam int unsigned EXPANDED_RAM_BYTES = 1024;
  localparam int unsigned IRAM_BYTES = 256;
  localparam int unsigned SFR_BYTES = 128;
  localparam logic [15:0] EXPANDED_RAM_FIRST = 16'h0000;
  localparam logic [15:0] EXPANDED_RAM_LAST = 16'h03FF;
  localparam logic [7:0] LOWER_LAST = 8'h7F;
  localparam logic [7:0] UPPER_FIRST = 8'h80;

  // Visible expanded RAM size for each size-select code
  localparam logic [15:0] XSIZE_SEL0 = 16'h0100;
  localparam logic [15:0] XSIZE_SEL1 = 16'h0200;
  localparam logic [15:0] XSIZE_SEL2 = 16'h0300;
  localparam logic [15:0] XSIZE_SEL3 = 16'h0400;

  // ==========================================================================
  // Timing counts in sys_clk periods
  localparam logic [4:0] PULSE_STD_CLK = 5'h06;
  localparam logic [4:0] PULSE_STR_CLK = 5'h1E;
  localparam logic [4:0] ALE_CLK = 5'h02;
  localparam logic [4:0] HOLD_CLK = 5'h01;

  // ==========================================================================
  // Register bus byte offsets and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int unsigned CTRL_DIS_BIT = 0;
  localparam int unsigned CTRL_SIZE_LO_BIT = 1;
  localparam int unsigned CTRL_SIZE_HI_BIT = 2;
  localparam int unsigned CTRL_STRETCH_BIT = 3;
  localparam logic CTRL_DIS_RST = 1'h0;
  localparam logic [1:0] CTRL_SIZE_RST = 2'h3;
  localparam logic CTRL_STRETCH_RST = 1'h0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_EXT_BIT = 1;
  localparam int unsigned STAT_EXPANDED_RAM_BIT = 2;
  localparam int unsigned STAT_WR_BIT = 3;

  // ==========================================================================
  // Access kinds issued by the core
  typedef enum logic [2:0] {
    XMA_DIRECT,
    XMA_INDIRECT,
    XMA_STACK,
    XMA_EXTERNAL_DATA_MOVE_IDX,
    XMA_EXTERNAL_DATA_MOVE_DATA_POINTER
  } xma_space_t;

  // Access sequencer states
  typedef enum logic [2:0] {
    XMA_IDLE,
    XMA_XWAIT,
    XMA_ALE,
    XMA_STROBE,
    XMA_HOLD
  } xma_state_t;

endpackage : xma_pkg

// ==== verif/xma_bus_peer.sv ====
// External multiplexed bus peripheral model with one write capture
`timescale 1ns/1ps
`default_nettype none
module xma_bus_peer (
  // Clock
  input wire logic sys_clk,
  // Bus pins from the block
  input wire logic [7:0] port_out,
  input wire logic oe_n,
  input wire logic [7:0] high_port,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  // Pin level back to the block and the cycle seen
  output logic [7:0] port_in,
  output logic [15:0] addr_q,
  output logic [7:0] wdata_q
);
  logic [7:0] last_q = 8'h5A;
  // Latch address during the address phase, data at the write strobe
  always_ff @(posedge sys_clk) begin
    if (ale) addr_q <= {high_port, port_out};
    if (!wr_n && !oe_n) wdata_q <= port_out;
    if (!rd_n) last_q <= port_in;
  end
  // Wire level: block drives, peer answers a read, else inverted stale value
  always_comb begin
    if (!oe_n) port_in = port_out;
    else if (!rd_n) port_in = addr_q[7:0] ^ addr_q[15:8] ^ 8'h3C;
    else port_in = ~last_q;
  end
endmodule : xma_bus_peer
`default_nettype wire

// ==== verif/xma_top_asserts.sv ====
// Port-level checks of the expanded data memory access block
`timescale 1ns/1ps
`default_nettype none
module xma_top_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Observed ports
  input wire logic clk_en,
  input wire logic core_req,
  input wire xma_pkg::xma_space_t core_space,
  input wire logic core_busy_q,
  input wire logic core_ack_q,
  input wire logic low_addr_data_port_oe_n_q,
  input wire logic [7:0] high_addr_port_q,
  input wire logic addr_latch_en_q,
  input wire logic rd_strobe_n_q,
  input wire logic wr_strobe_n_q,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ==========================================================================
  // Strobe low-time counter
  logic [5:0] low_q;
  logic take;
  assign take = clk_en && core_req && !core_busy_q;
  always_ff @(posedge sys_clk) begin
    if (srst || (rd_strobe_n_q && wr_strobe_n_q)) low_q <= 6'h00;
    else low_q <= low_q + 6'h01;
  end
  // Address phase then a strobe
  sequence addr_phase_s;
    addr_latch_en_q ##1 addr_latch_en_q && !low_addr_data_port_oe_n_q;
  endsequence
  sequence strobe_s;
    !addr_latch_en_q && (!rd_strobe_n_q || !wr_strobe_n_q);
  endsequence
  // ==========================================================================
  // Assertions
  strobe_excl_a: assert property (rd_strobe_n_q || wr_strobe_n_q)
    else $error("both strobes low");
  bus_phases_a: assert property ($rose(addr_latch_en_q) |-> addr_phase_s ##1 strobe_s)
    else $error("bus cycle phases wrong");
  pulse_width_a: assert property ($rose(rd_strobe_n_q && wr_strobe_n_q)
    |-> (low_q == 6'h06 || low_q == 6'h1E)) else $error("strobe width wrong");
  read_release_a: assert property (!rd_strobe_n_q |-> low_addr_data_port_oe_n_q)
    else $error("port driven in read");
  write_drive_a: assert property (!wr_strobe_n_q |-> !low_addr_data_port_oe_n_q)
    else $error("port not driven in write");
  high_hold_a: assert property (!(rd_strobe_n_q && wr_strobe_n_q)
    |-> $stable(high_addr_port_q)) else $error("high port moved in strobe");
  inner_ack_a: assert property (take && core_space inside {xma_pkg::XMA_DIRECT,
    xma_pkg::XMA_INDIRECT, xma_pkg::XMA_STACK} |=> core_ack_q) else $error("late inner ack");
  move_busy_a: assert property (take && core_space inside {xma_pkg::XMA_EXTERNAL_DATA_MOVE_IDX,
    xma_pkg::XMA_EXTERNAL_DATA_MOVE_DATA_POINTER} |=> core_busy_q && !core_ack_q) else $error("move not busy");
  wait_pulse_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("waitrequest pulse wrong");
endmodule : xma_top_asserts
bind xma_top xma_top_asserts u_chk (.sys_clk, .srst, .clk_en, .core_req, .core_space,
  .core_busy_q, .core_ack_q, .low_addr_data_port_oe_n_q, .high_addr_port_q,
  .addr_latch_en_q, .rd_strobe_n_q, .wr_strobe_n_q, .avs_read, .avs_write, .avs_waitrequest);
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking testbench for the expanded data memory access block
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================================
  // Signals
  logic sys_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, core_req = 1'b0, core_wr = 1'b0;
  xma_pkg::xma_space_t core_space = xma_pkg::XMA_DIRECT;
  logic [15:0] core_addr = 16'h0000, peer_addr;
  logic [7:0] core_wdata = 8'h00, core_rdata_q, low_addr_data_port_in, low_addr_data_port_out_q;
  logic [7:0] high_addr_port_q, peer_wdata, q8;
  logic core_busy_q, core_ack_q, low_addr_data_port_oe_n_q, addr_latch_en_q, pins;
  logic rd_strobe_n_q, wr_strobe_n_q, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q32;
  int cyc, n_fail = 0, check_count = 0;
  always #50 sys_clk = ~sys_clk;
  xma_top DUT (.sys_clk, .srst, .clk_en, .core_req, .core_wr, .core_space, .core_addr,
    .core_wdata, .core_busy_q, .core_ack_q, .core_rdata_q, .low_addr_data_port_in,
    .low_addr_data_port_out_q, .low_addr_data_port_oe_n_q, .high_addr_port_q,
    .addr_latch_en_q, .rd_strobe_n_q, .wr_strobe_n_q, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
  xma_bus_peer u_peer (.sys_clk(sys_clk), .port_out(low_addr_data_port_out_q),
    .oe_n(low_addr_data_port_oe_n_q), .high_port(high_addr_port_q), .ale(addr_latch_en_q),
    .rd_n(rd_strobe_n_q), .wr_n(wr_strobe_n_q), .port_in(low_addr_data_port_in),
    .addr_q(peer_addr), .wdata_q(peer_wdata));
  // ==========================================================================
  // Compare, bus and closing tasks
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // Avalon transfer held until waitrequest is sampled low; the watchdog ends a hang
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q32 = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av
  // Core access; counts cycles from the taking edge and notes any pin activity
  task automatic xp(input xma_pkg::xma_space_t s, input logic w, input logic [15:0] a,
      input logic [7:0] d, input int ec, input logic ep);
    @(posedge sys_clk);
    core_space <= s;
    core_wr <= w;
    core_addr <= a;
    core_wdata <= d;
    core_req <= 1'b1;
    @(posedge sys_clk);
    core_req <= 1'b0;
    cyc = 0;
    pins = 1'b0;
    while (cyc < 60) begin
      #1;
      cyc++;
      pins |= addr_latch_en_q | ~rd_strobe_n_q | ~wr_strobe_n_q | ~low_addr_data_port_oe_n_q;
      if (core_ack_q === 1'b1) break;
      @(posedge sys_clk);
    end
    q8 = core_rdata_q;
    if (!w) chk_word("read data", {24'h0, d}, {24'h0, q8});
    chk_word("cycles", ec, cyc);
    chk_word("pin activity", {31'h0, ep}, {31'h0, pins});
  endtask : xp
  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    av(1'b0, 4'h0, 32'h0);
    chk_word("ctrl reset", 32'h6, q32);
    av(1'b1, 4'h8, 32'hFFFFFFFF);
    av(1'b0, 4'h8, 32'h0);
    chk_word("unmapped", 32'h0, q32);
  endtask : t_regs
  task automatic t_iram;
    xp(xma_pkg::XMA_DIRECT, 1'b1, 16'h0010, 8'hA5, 1, 1'b0);
    xp(xma_pkg::XMA_INDIRECT, 1'b0, 16'h0010, 8'hA5, 1, 1'b0);
    xp(xma_pkg::XMA_DIRECT, 1'b1, 16'h0090, 8'h11, 1, 1'b0);
    xp(xma_pkg::XMA_INDIRECT, 1'b1, 16'h0090, 8'h22, 1, 1'b0);
    xp(xma_pkg::XMA_DIRECT, 1'b0, 16'h0090, 8'h11, 1, 1'b0);
    xp(xma_pkg::XMA_INDIRECT, 1'b0, 16'h0090, 8'h22, 1, 1'b0);
    xp(xma_pkg::XMA_STACK, 1'b0, 16'h0090, 8'h22, 1, 1'b0);
  endtask : t_iram
  // Clock enable low: a request is neither answered nor written
  task automatic t_hold;
    xp(xma_pkg::XMA_DIRECT, 1'b1, 16'h0020, 8'h11, 1, 1'b0);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    core_space <= xma_pkg::XMA_DIRECT;
    core_wr <= 1'b1;
    core_addr <= 16'h0020;
    core_wdata <= 8'h5E;
    core_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk_word("frozen ack", 32'h0, {31'h0, core_ack_q});
    @(posedge sys_clk);
    core_req <= 1'b0;
    clk_en <= 1'b1;
    xp(xma_pkg::XMA_DIRECT, 1'b0, 16'h0020, 8'h11, 1, 1'b0);
  endtask : t_hold
  task automatic t_expanded_ram;
    xp(xma_pkg::XMA_EXTERNAL_DATA_MOVE_DATA_POINTER, 1'b1, 16'h03FF, 8'h5C, 7, 1'b0);
    xp(xma_pkg::XMA_EXTERNAL_DATA_MOVE_DATA_POINTER, 1'b0, 16'h03FF, 8'h5C, 7, 1'b0);
    xp(xma_pkg::XMA_EXTERNAL_DATA_MOVE_IDX, 1'b1, 16'h00A0, 8'h77, 7, 1'b0);
    xp(xma_pkg::XMA_EXTERNAL_DATA_MOVE_DATA_POINTER, 1'b0, 16'h00A0, 8'h77, 7, 1'b0);
    xp(xma_pkg::XMA_EXTERNAL_DATA_MOVE_DATA_POINTER, 1'b1, 16'h00FF, 8'h12, 7, 1'b0);
    xp(xma_pkg::XMA_EXTERNAL_DATA_MOVE_IDX, 1'b0, 16'h03FF, 8'h12, 7, 1'b0);
    xp(xma_pkg::XMA_STACK, 1'b1, 16'h00A0, 8'h99, 1, 1'b0);
    xp(xma_pkg::XMA_EXTERNAL_DATA_MOVE_DATA_POINTER, 1'b0, 16'h00A0, 8'h77, 7, 1'b0);
    av(1'b0, 4'h4, 32'h0);
    chk_word("status after ram read", 32'h4, q32);
  endtask : t_expanded_ram
  task automatic t_bus;
    xp(xma_pkg::XMA_EXTERNAL_DATA_MOVE_DATA_POINTER, 1'b1, 16'h0400, 8'hE7, 10, 1'b1);
    chk_word("bus write", {8'h0, 16'h0400, 8'hE7}, {8'h0, peer_addr, peer_wdata});
    xp(xma_pkg::XMA_EXTERNAL_DATA_MOVE_DATA_POINTER, 1'b0, 16'h1234, 8'h1A, 10, 1'b1);
    chk_word("high port", 32'h12, {24'h0, high_addr_port_q});
    av(1'b0, 4'h4, 32'h0);
    chk_word("status after bus read", 32'h2, q32);
  endtask : t_bus
  task automatic t_size;
    av(1'b1, 4'h0, 32'h0);
    xp(xma_pkg::XMA_EXTERNAL_DATA_MOVE_DATA_POINTER, 1'b0, 16'h0100, 8'h3D, 10, 1'b1);
    chk_word("hidden address", 32'h0100, {16'h0, peer_addr});
    xp(xma_pkg::XMA_EXTERNAL_DATA_MOVE_DATA_POINTER, 1'b0, 16'h00FF, 8'h12, 7, 1'b0);
  endtask : t_size
  task automatic t_dis;
    av(1'b1, 4'h0, 32'h1);
    xp(xma_pkg::XMA_EXTERNAL_DATA_MOVE_IDX, 1'b0, 16'h0055, 8'h68, 10, 1'b1);
    chk_word("index address", 32'h0155, {16'h0, peer_addr});
    xp(xma_pkg::XMA_EXTERNAL_DATA_MOVE_DATA_POINTER, 1'b1, 16'h00FF, 8'h44, 10, 1'b1);
    chk_word("pointer write", {8'h0, 16'h00FF, 8'h44}, {8'h0, peer_addr, peer_wdata});
  endtask : t_dis
  task automatic t_str;
    av(1'b1, 4'h0, 32'hE);
    xp(xma_pkg::XMA_EXTERNAL_DATA_MOVE_DATA_POINTER, 1'b0, 16'h00FF, 8'h12, 31, 1'b0);
    xp(xma_pkg::XMA_EXTERNAL_DATA_MOVE_DATA_POINTER, 1'b1, 16'h0400, 8'h3A, 34, 1'b1);
    chk_word("stretched write", 32'h3A, {24'h0, peer_wdata});
  endtask : t_str
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_iram();
    t_hold();
    t_expanded_ram();
    t_bus();
    t_size();
    t_dis();
    t_str();
    stop_test();
  end
  initial begin
    #500000;
    n_fail++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
